// >>> compact_isa_decode_cond_check.sv
/*
 Condition check, status field mask, second-operand split and compact-word
 decoder of the core. Every result appears one clock after its input.
 Condition pass and done pulse for one cycle per request; a reserved code
 never passes. Field mask and operand split follow their inputs every cycle.
 Format and fields hold the last decoded word; done and undefined pulse.
 Unused fields read as zero, except the shared register and load fields.
 Long-branch halves are decoded one at a time; execute pairs them.
 Assumes inputs are synchronous to clk and held by fetch for one cycle each,
 that nrst is asserted before the first request, and that execute samples
 the pulses in the cycle they stand.
*/
// Summary of operation
// RQ1 - Single-flag conditions test zero, carry, negative, overflow
// RQ2 - Unsigned above: carry set, zero clear; else at-most
// RQ3 - Signed at-least when negative equals overflow
// RQ4 - Signed above/at-most add zero flag to that
// RQ5 - Always condition passes regardless of flags
// RQ6 - Field suffixes set mask bits zero to three
// RQ7 - Second operand: immediate or shifted register, RRX
// RQ8 - Top 001: move/compare/add/subtract immediate
// RQ9 - Top 010001: high register op or exchange
// RQ10 - 0101 with bit9 set: sign-extended transfers
// RQ11 - Top 011: immediate-offset byte/word transfer
// RQ12 - Top 1000: halfword transfer, five-bit offset
// RQ13 - Top 1001: stack-pointer relative transfer
// RQ14 - Top 10110000: stack pointer adjust, sign bit
// RQ15 - 1011 L10R: push or pop list
// RQ16 - Top 1100: multiple load or store
// RQ17 - Top 1111: one long-branch-with-link half
// RQ18 - Compare any low/high register pairing
// RQ19 - Add signed seven-bit immediate to stack pointer
// RQ20 - Unmatched words flagged undefined
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"

module compact_isa_decode_cond_check (
   input wire logic clk,
   input wire logic nrst,
   input wire logic condValid,
   input wire logic [3:0] condCode,
   input wire cdc_pkg::flags_t flags,
   input wire cdc_pkg::fieldSel_t fieldSel,
   input wire cdc_pkg::op2In_t op2In,
   input wire logic wordValid,
   input wire logic [15:0] word,
   output logic condDone,
   output logic condPass,
   output logic [3:0] fieldMask,
   output cdc_pkg::op2Out_t op2Out,
   output logic wordDone,
   output cdc_pkg::format_t format,
   output cdc_pkg::compactFields_t fields,
   output logic undefined
);
   import cdc_pkg::*;

   logic condPass_d;
   logic condPass_q;
   logic condDone_q;
   logic [3:0] fieldMask_d;
   logic [3:0] fieldMask_q;
   op2Out_t op2_d;
   op2Out_t op2_q;
   format_t format_d;
   format_t format_q;
   compactFields_t fields_d;
   compactFields_t fields_q;
   logic wordDone_q;
   logic undefined_d;
   logic undefined_q;

   logic signsMatch;
   logic unsignedAbove;

   // Shared terms of the signed and unsigned tests
   assign signsMatch = flags.negative == flags.overflow;
   assign unsignedAbove = flags.carry && !flags.zero;

   // Condition evaluation
   always_comb begin
      case (condCode)
         // RQ1 single-flag tests
         `CC_ZSET: condPass_d = flags.zero;
         `CC_ZCLR: condPass_d = !flags.zero;
         `CC_CSET: condPass_d = flags.carry;
         `CC_CCLR: condPass_d = !flags.carry;
         `CC_NSET: condPass_d = flags.negative;
         `CC_NCLR: condPass_d = !flags.negative;
         `CC_VSET: condPass_d = flags.overflow;
         `CC_VCLR: condPass_d = !flags.overflow;
         // RQ2 unsigned comparisons
         `CC_UABOVE: condPass_d = unsignedAbove;
         `CC_UATMOST: condPass_d = !unsignedAbove;
         // RQ3 signed sign tests
         `CC_SATLEAST: condPass_d = signsMatch;
         `CC_SBELOW: condPass_d = !signsMatch;
         // RQ4 signed with zero
         `CC_SABOVE: condPass_d = !flags.zero && signsMatch;
         `CC_SATMOST: condPass_d = flags.zero || !signsMatch;
         // RQ5 always passes
         `CC_ALWAYS: condPass_d = 1'b1;
         // Reserved code never passes, so it cannot steer execution
         default: condPass_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         condDone_q <= 1'b0;
      end else begin
         condDone_q <= condValid;
      end
   end

   // Pass gated by request, so stale flags never show
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         condPass_q <= 1'b0;
      end else begin
         condPass_q <= condValid && condPass_d;
      end
   end

   // RQ6 field mask bits
   always_comb begin
      fieldMask_d = `RST_MASK;
      fieldMask_d[`MASK_FLAGS_BIT] = fieldSel.flagsSel;
      fieldMask_d[`MASK_STATUS_BIT] = fieldSel.statusSel;
      fieldMask_d[`MASK_EXT_BIT] = fieldSel.extSel;
      fieldMask_d[`MASK_CTRL_BIT] = fieldSel.ctrlSel;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fieldMask_q <= `RST_MASK;
      end else begin
         fieldMask_q <= fieldMask_d;
      end
   end

   // RQ7 second operand split
   always_comb begin
      op2_d = '0;
      op2_d.isImm = op2In.immediate;
      if (op2In.immediate) begin
         op2_d.rotate = op2In.bits[11:8];
         op2_d.imm8 = op2In.bits[7:0];
      end else begin
         op2_d.rm = op2In.bits[3:0];
         op2_d.shiftType = op2In.bits[6:5];
         op2_d.shiftByReg = op2In.bits[4];
         if (op2In.bits[4]) begin
            op2_d.rs = op2In.bits[11:8];
         end else begin
            op2_d.shiftAmount = op2In.bits[11:7];
            // Rotate by zero immediate means one-bit extended rotate
            op2_d.isRrx = (op2In.bits[6:5] == `SHIFT_ROR) && (op2In.bits[11:7] == 5'h00);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op2_q <= '0;
      end else begin
         op2_q <= op2_d;
      end
   end

   // Compact word classification and field extraction
   always_comb begin
      fields_d = '0;
      format_d = FMT_UNDEF;
      fields_d.destReg = {1'b0, word[2:0]};
      fields_d.source_reg_field = {1'b0, word[5:3]};
      fields_d.base_reg_field = word[5:3];
      fields_d.loadBit = word[11];
      case (word[15:13])
         3'h0: begin
            if (word[12:11] == 2'h3) begin
               format_d = FMT_ADDSUB;
               fields_d.opcode = {3'h0, word[9]};
               fields_d.immValue = {8'h00, word[8:6]};
            end else begin
               format_d = FMT_SHIFT;
               fields_d.opcode = {2'h0, word[12:11]};
               fields_d.immValue = {6'h00, word[10:6]};
            end
         end
         // RQ8 immediate move, compare, add, subtract
         3'h1: begin
            format_d = FMT_IMM8;
            fields_d.opcode = {2'h0, word[12:11]};
            fields_d.destReg = {1'b0, word[10:8]};
            fields_d.immValue = {3'h0, word[7:0]};
            fields_d.isCompare = word[12:11] == `IMM8_CMP_OP;
         end
         3'h2: begin
            if (word[12:10] == 3'h0) begin
               format_d = FMT_ALU;
               fields_d.opcode = word[9:6];
               fields_d.isCompare = (word[9:6] == `ALU_CMP_OP) || (word[9:6] == `ALU_CMN_OP);
            end else if (word[12:10] == 3'h1) begin
               // RQ9 high registers reach r8 to r15
               format_d = FMT_HIREG;
               fields_d.opcode = {2'h0, word[9:8]};
               fields_d.first_high_sel = word[7];
               fields_d.second_high_sel = word[6];
               fields_d.destReg = {word[7], word[2:0]};
               fields_d.source_reg_field = {word[6], word[5:3]};
               // RQ18 compare any register pairing
               fields_d.isCompare = word[9:8] == `HIREG_CMP_OP;
            end else if (word[12:11] == 2'h1) begin
               format_d = FMT_PCLOAD;
               fields_d.destReg = {1'b0, word[10:8]};
               fields_d.immValue = {3'h0, word[7:0]};
            end else if (!word[9]) begin
               format_d = FMT_REGOFF;
               fields_d.byteBit = word[10];
               fields_d.index_reg_field = word[8:6];
            end else begin
               // RQ10 sign-extended byte or halfword
               format_d = FMT_SIGNEXT;
               fields_d.halfBit = word[11];
               fields_d.signBit = word[10];
               fields_d.loadBit = word[11] || word[10];
               fields_d.index_reg_field = word[8:6];
            end
         end
         // RQ11 immediate offset transfer
         3'h3: begin
            format_d = FMT_IMMOFF;
            fields_d.byteBit = word[12];
            fields_d.immValue = {6'h00, word[10:6]};
         end
         3'h4: begin
            if (!word[12]) begin
               // RQ12 halfword transfer
               format_d = FMT_HALF;
               fields_d.immValue = {6'h00, word[10:6]};
            end else begin
               // RQ13 stack-relative transfer
               format_d = FMT_SPREL;
               fields_d.destReg = {1'b0, word[10:8]};
               fields_d.immValue = {3'h0, word[7:0]};
            end
         end
         3'h5: begin
            if (!word[12]) begin
               format_d = FMT_LDADDR;
               fields_d.extraReg = word[11];
               fields_d.destReg = {1'b0, word[10:8]};
               fields_d.immValue = {3'h0, word[7:0]};
            end else if (word[11:8] == 4'h0) begin
               // RQ14 RQ19 stack pointer adjust
               format_d = FMT_SPADJ;
               fields_d.spSubtract = word[7];
               fields_d.immValue = {4'h0, word[6:0]};
            end else if (word[10:9] == 2'h2) begin
               // RQ15 push or pop
               format_d = FMT_PUSHPOP;
               fields_d.extraReg = word[8];
               fields_d.regList = word[7:0];
            end
         end
         3'h6: begin
            if (!word[12]) begin
               // RQ16 multiple transfer
               format_d = FMT_MULTI;
               fields_d.base_reg_field = word[10:8];
               fields_d.regList = word[7:0];
            end else if (word[11:8] == 4'hf) begin
               format_d = FMT_SWI;
               fields_d.immValue = {3'h0, word[7:0]};
            end else if (word[11:8] != `CC_ALWAYS) begin
               format_d = FMT_CONDBR;
               fields_d.opcode = word[11:8];
               fields_d.immValue = {3'h0, word[7:0]};
            end
         end
         default: begin
            if (!word[12] && !word[11]) begin
               format_d = FMT_BRANCH;
               fields_d.immValue = word[10:0];
            end else if (word[12]) begin
               // RQ17 long branch half
               format_d = FMT_LONGBL;
               fields_d.longHigh = word[11];
               fields_d.immValue = word[10:0];
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wordDone_q <= 1'b0;
      end else begin
         wordDone_q <= wordValid;
      end
   end

   // Hold last result so execute may sample late
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         format_q <= FMT_UNDEF;
      end else if (wordValid) begin
         format_q <= format_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fields_q <= '0;
      end else if (wordValid) begin
         fields_q <= fields_d;
      end
   end

   // Own flop, so the pin carries no gate after a register
   // RQ20 unmatched word flag
   assign undefined_d = wordValid && (format_d == FMT_UNDEF);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         undefined_q <= 1'b0;
      end else begin
         undefined_q <= undefined_d;
      end
   end

   assign condDone = condDone_q;
   assign condPass = condPass_q;
   assign fieldMask = fieldMask_q;
   assign op2Out = op2_q;
   assign wordDone = wordDone_q;
   assign format = format_q;
   assign fields = fields_q;
   assign undefined = undefined_q;

endmodule // compact_isa_decode_cond_check
`default_nettype wire

// >>> cdc_defs.svh
/*
 Constants for the condition check, field mask and compact-word decoder.
 Included by the package and the decoder; holds definitions only.
*/
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH

// Condition codes
`define CC_ZSET 4'h0
`define CC_ZCLR 4'h1
`define CC_CSET 4'h2
`define CC_CCLR 4'h3
`define CC_NSET 4'h4
`define CC_NCLR 4'h5
`define CC_VSET 4'h6
`define CC_VCLR 4'h7
`define CC_UABOVE 4'h8
`define CC_UATMOST 4'h9
`define CC_SATLEAST 4'ha
`define CC_SBELOW 4'hb
`define CC_SABOVE 4'hc
`define CC_SATMOST 4'hd
`define CC_ALWAYS 4'he

// Status-register field mask bit positions
`define MASK_FLAGS_BIT 0
`define MASK_STATUS_BIT 1
`define MASK_EXT_BIT 2
`define MASK_CTRL_BIT 3

// Shift type encodings of the second operand
`define SHIFT_LSL 2'h0
`define SHIFT_LSR 2'h1
`define SHIFT_ASR 2'h2
`define SHIFT_ROR 2'h3

// Compact opcodes that compare
`define IMM8_CMP_OP 2'h1
`define HIREG_CMP_OP 2'h1
`define ALU_CMP_OP 4'ha
`define ALU_CMN_OP 4'hb

// Reset values
`define RST_MASK 4'h0
`define RST_WORD 16'h0000

`endif

// >>> cdc_pkg.sv
/*
 Types shared by the decoder and its testbench.
 Assumes cdc_defs.svh is reachable on the include path.
*/
`include "cdc_defs.svh"

package cdc_pkg;

   typedef struct packed {
      logic negative;
      logic zero;
      logic carry;
      logic overflow;
   } flags_t;

   typedef struct packed {
      logic ctrlSel;
      logic extSel;
      logic statusSel;
      logic flagsSel;
   } fieldSel_t;

   typedef struct packed {
      logic immediate;
      logic [11:0] bits;
   } op2In_t;

   typedef struct packed {
      logic isImm;
      logic [7:0] imm8;
      logic [3:0] rotate;
      logic [3:0] rm;
      logic [1:0] shiftType;
      logic shiftByReg;
      logic [3:0] rs;
      logic [4:0] shiftAmount;
      logic isRrx;
   } op2Out_t;

   typedef enum logic [4:0] {
      FMT_SHIFT, FMT_ADDSUB, FMT_IMM8, FMT_ALU, FMT_HIREG, FMT_PCLOAD,
      FMT_REGOFF, FMT_SIGNEXT, FMT_IMMOFF, FMT_HALF, FMT_SPREL, FMT_LDADDR,
      FMT_SPADJ, FMT_PUSHPOP, FMT_MULTI, FMT_CONDBR, FMT_SWI, FMT_BRANCH,
      FMT_LONGBL, FMT_UNDEF
   } format_t;

   typedef struct packed {
      logic [3:0] destReg;
      logic [3:0] source_reg_field;
      logic [2:0] base_reg_field;
      logic [2:0] index_reg_field;
      logic [3:0] opcode;
      logic loadBit;
      logic byteBit;
      logic halfBit;
      logic signBit;
      logic first_high_sel;
      logic second_high_sel;
      logic extraReg;
      logic spSubtract;
      logic longHigh;
      logic isCompare;
      logic [7:0] regList;
      logic [10:0] immValue;
   } compactFields_t;

endpackage

// >>> compact_isa_decode_cond_check_monitor.sv
/* Port checker for the decoder.
 Assumes cdc_pkg and cdc_defs.svh are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module compact_isa_decode_cond_check_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic condValid,
   input wire logic [3:0] condCode,
   input wire cdc_pkg::flags_t flags,
   input wire cdc_pkg::fieldSel_t fieldSel,
   input wire cdc_pkg::op2In_t op2In,
   input wire logic wordValid,
   input wire logic [15:0] word,
   input wire logic condDone,
   input wire logic condPass,
   input wire logic [3:0] fieldMask,
   input wire cdc_pkg::op2Out_t op2Out,
   input wire logic wordDone,
   input wire cdc_pkg::format_t format,
   input wire cdc_pkg::compactFields_t fields,
   input wire logic undefined
);
   import cdc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_DONE: assert property (condValid |=> condDone) else $error("no done");
   AST_IDLE: assert property (!condValid |=> !condDone && !condPass) else $error("stray pass");
   AST_ZERO: assert property (condValid && condCode == `CC_ZSET
      |=> condPass == $past(flags.zero)) else $error("zero test");
   AST_UABOVE: assert property (condValid && condCode == `CC_UABOVE
      |=> condPass == ($past(flags.carry) && !$past(flags.zero))) else $error("above test");
   AST_SBELOW: assert property (condValid && condCode == `CC_SBELOW
      |=> condPass == ($past(flags.negative) != $past(flags.overflow))) else $error("below test");
   AST_SATMOST: assert property (condValid && condCode == `CC_SATMOST
      |=> condPass == ($past(flags.zero) || $past(flags.negative) != $past(flags.overflow)))
      else $error("at-most test");
   AST_ALWAYS: assert property (condValid && condCode == `CC_ALWAYS |=> condPass) else $error("always");
   AST_MASK: assert property ($past(nrst) |-> fieldMask == $past(fieldSel)) else $error("mask");
   AST_UNDEF: assert property (undefined |-> wordDone && format == FMT_UNDEF) else $error("undef");
   AST_IMM8: assert property (wordValid && word[15:13] == 3'h1
      |=> format == FMT_IMM8 && fields.immValue[7:0] == $past(word[7:0])) else $error("imm8");
   AST_LONG: assert property (wordValid && word[15:12] == 4'hf
      |=> format == FMT_LONGBL && fields.longHigh == $past(word[11])) else $error("long");
   CV_PASS: cover property (condDone && condPass);
   CV_UNDEF: cover property (undefined);
   CV_B2B: cover property (wordValid ##1 wordValid);
endmodule // compact_isa_decode_cond_check_monitor
bind compact_isa_decode_cond_check compact_isa_decode_cond_check_monitor mon (.clk(clk), .nrst(nrst),
   .condValid(condValid), .condCode(condCode), .flags(flags), .fieldSel(fieldSel), .op2In(op2In),
   .wordValid(wordValid), .word(word), .condDone(condDone), .condPass(condPass), .fieldMask(fieldMask),
   .op2Out(op2Out), .wordDone(wordDone), .format(format), .fields(fields), .undefined(undefined));
`default_nettype wire

// >>> test_compact_isa_decode_cond_check.sv
/* Self-checking bench for the decoder.
 Assumes the package and the design are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.svh"
module test_compact_isa_decode_cond_check;
   import cdc_pkg::*;
   logic clk, nrst, condValid, wordValid, condDone, condPass, wordDone, undefined;
   logic [3:0] condCode, fieldMask;
   logic [15:0] word;
   flags_t flags;
   fieldSel_t fieldSel;
   op2In_t op2In;
   op2Out_t op2Out;
   format_t format;
   compactFields_t fields;
   int n_errors = 0;
   int n_tests = 0;
   compact_isa_decode_cond_check DUT (.clk(clk), .nrst(nrst), .condValid(condValid), .condCode(condCode),
      .flags(flags), .fieldSel(fieldSel), .op2In(op2In), .wordValid(wordValid), .word(word),
      .condDone(condDone), .condPass(condPass), .fieldMask(fieldMask), .op2Out(op2Out),
      .wordDone(wordDone), .format(format), .fields(fields), .undefined(undefined));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic expPass(input logic [3:0] c, input flags_t f);
      case (c)
         `CC_ZSET: return f.zero;
         `CC_ZCLR: return !f.zero;
         `CC_CSET: return f.carry;
         `CC_CCLR: return !f.carry;
         `CC_NSET: return f.negative;
         `CC_NCLR: return !f.negative;
         `CC_VSET: return f.overflow;
         `CC_VCLR: return !f.overflow;
         `CC_UABOVE: return f.carry && !f.zero;
         `CC_UATMOST: return !f.carry || f.zero;
         `CC_SATLEAST: return f.negative == f.overflow;
         `CC_SBELOW: return f.negative != f.overflow;
         `CC_SABOVE: return !f.zero && f.negative == f.overflow;
         `CC_SATMOST: return f.zero || f.negative != f.overflow;
         `CC_ALWAYS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   // Every code against every flag set, back to back
   task automatic test_cond();
      logic [3:0] c;
      flags_t f;
      for (int i = 0; i <= 256; i++) begin
         @(posedge clk);
         condValid <= i < 256;
         condCode <= i[3:0];
         flags <= i[7:4];
         #1;
         if (i > 0) begin
            chk(condDone, 1);
            chk(condPass, expPass(c, f));
         end
         c = i[3:0];
         f = i[7:4];
      end
      @(posedge clk);
      #1;
      chk({condDone, condPass}, 0);
      $display("test_cond done");
   endtask
   task automatic test_mask();
      for (int i = 0; i < 17; i++) begin
         @(posedge clk);
         fieldSel <= i[3:0];
         #1;
         if (i > 0) chk(fieldMask, 16'(i - 1));
      end
      $display("test_mask done");
   endtask
   // Shift kinds by immediate and by register, then immediate, then RRX
   task automatic test_op2();
      for (int t = 0; t < 10; t++) begin
         @(posedge clk);
         op2In <= t == 8 ? 13'h1a5c : t == 9 ? 13'h0066 : {1'b0, 5'h12, t[1:0], t[2], 4'h6};
         @(posedge clk);
         #1;
         chk(op2Out.isImm, t == 8);
         if (t == 8) chk({op2Out.rotate, op2Out.imm8}, 16'ha5c);
         else begin
            chk({op2Out.rm, op2Out.isRrx}, {4'h6, t == 9});
            if (t < 8) chk({op2Out.shiftType, op2Out.shiftByReg}, {t[1:0], t[2]});
            if (t < 8) chk(t[2] ? op2Out.rs : op2Out.shiftAmount, t[2] ? 5'h9 : 5'h12);
         end
      end
      $display("test_op2 done");
   endtask
   task automatic dec(input logic [15:0] w, input format_t fm);
      @(posedge clk);
      wordValid <= 1;
      word <= w;
      @(posedge clk);
      wordValid <= 0;
      #1;
      chk({wordDone, 11'h0, format}, {1'b1, 11'h0, fm});
      chk(undefined, fm == FMT_UNDEF);
   endtask
   task automatic test_words();
      dec(16'h2aff, FMT_IMM8);
      chk({fields.opcode, fields.destReg, fields.immValue[7:0], fields.isCompare}, 17'h025ff);
      for (int h = 0; h < 4; h++) begin
         dec({8'h45, h[1:0], 6'h1a}, FMT_HIREG);
         chk({fields.destReg, fields.source_reg_field, fields.isCompare}, {h[1], 3'd2, h[0], 3'd3, 1'b1});
         chk({fields.first_high_sel, fields.second_high_sel}, h[1:0]);
      end
      dec(16'h5f5a, FMT_SIGNEXT);
      chk({fields.halfBit, fields.signBit, fields.index_reg_field, fields.base_reg_field, fields.destReg}, 16'heb2);
      dec(16'h7d5a, FMT_IMMOFF);
      chk({fields.byteBit, fields.loadBit, fields.immValue, fields.base_reg_field}, {2'h3, 11'h15, 3'd3});
      dec(16'h8d5a, FMT_HALF);
      chk({fields.loadBit, fields.immValue, fields.base_reg_field}, {1'b1, 11'h15, 3'd3});
      dec(16'h95c3, FMT_SPREL);
      chk({fields.loadBit, fields.destReg, fields.immValue}, {1'b0, 4'd5, 11'hc3});
      dec(16'hb0ff, FMT_SPADJ);
      chk({fields.spSubtract, fields.immValue}, 16'h87f);
      dec(16'hb005, FMT_SPADJ);
      chk({fields.spSubtract, fields.immValue}, 16'h005);
      dec(16'hbda5, FMT_PUSHPOP);
      chk({fields.loadBit, fields.extraReg, fields.regList}, 16'h3a5);
      dec(16'hb4ff, FMT_PUSHPOP);
      chk({fields.loadBit, fields.extraReg, fields.regList}, 16'h0ff);
      dec(16'hc63c, FMT_MULTI);
      chk({fields.loadBit, fields.base_reg_field, fields.regList}, 16'h63c);
      dec(16'hfabc, FMT_LONGBL);
      chk({fields.longHigh, fields.immValue}, 16'habc);
      dec(16'hf123, FMT_LONGBL);
      chk({fields.longHigh, fields.immValue}, 16'h123);
      dec(16'h429a, FMT_ALU);
      chk({fields.opcode, fields.isCompare}, {4'ha, 1'b1});
      dec(16'h0812, FMT_SHIFT);
      dec(16'h1c12, FMT_ADDSUB);
      dec(16'h4b12, FMT_PCLOAD);
      dec(16'h5012, FMT_REGOFF);
      dec(16'ha812, FMT_LDADDR);
      dec(16'hd012, FMT_CONDBR);
      dec(16'hdf12, FMT_SWI);
      dec(16'he012, FMT_BRANCH);
      dec(16'hde12, FMT_UNDEF);
      dec(16'he812, FMT_UNDEF);
      dec(16'hb100, FMT_UNDEF);
      @(posedge clk);
      #1;
      chk({wordDone, undefined}, 0);
      $display("test_words done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Tests need under 500 cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   initial begin
      nrst = 0;
      condValid = 0;
      condCode = 0;
      flags = 0;
      fieldSel = 0;
      op2In = 0;
      wordValid = 0;
      word = 0;
      repeat (12) @(posedge clk);
      nrst <= 1;
      test_cond();
      test_mask();
      test_op2();
      test_words();
      wrap_up();
   end
endmodule // test_compact_isa_decode_cond_check
`default_nettype wire
